// >>> rtl/dbahp_device.sv
`timescale 1ns/1ps
`default_nettype none
module dbahp_device (
  input  wire logic  clk_i,
  input  wire logic  rst_n_i,
  input  wire logic  en_i,
  input  wire logic [1:0] cpu_mode_i,
  input  wire logic  dma_req_i,
  input  wire logic  dma_cycle_end_i,
  output logic       dma_go_o,
  output logic       dma_suspended_o,
  output logic [15:0] ctrl_o,
  dbahp_if.device    bus
);
  dbahp_pkg::dbahp_arb_state_t st_q;
  logic        grant;
  logic        mode0;
  logic [1:0]  mstate_q;
  logic        suspended_q;
  logic        sl_oe;
  logic [15:0] status;

  assign mode0 = (cpu_mode_i == dbahp_pkg::CPU_MODE0);
  assign grant = mode0 ? bus.hold_grant : !bus.bus_grant_n;

  // Arbiter state machine.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q        <= dbahp_pkg::DBAHP_ARB_IDLE;
      suspended_q <= 1'b0;
    end else if (en_i) begin
      case (st_q)
        dbahp_pkg::DBAHP_ARB_IDLE: begin
          if (dma_req_i) st_q <= dbahp_pkg::DBAHP_ARB_REQ;
        end
        dbahp_pkg::DBAHP_ARB_REQ: begin
          if (grant && bus.busy) begin
            st_q        <= dbahp_pkg::DBAHP_ARB_OWN;
            suspended_q <= 1'b0;
          end else if (!dma_req_i && !suspended_q) begin
            st_q <= dbahp_pkg::DBAHP_ARB_IDLE;
          end
        end
        dbahp_pkg::DBAHP_ARB_OWN: begin
          if (!grant) begin
            st_q <= dbahp_pkg::DBAHP_ARB_SUSPEND;
          end else if (!dma_req_i && dma_cycle_end_i) begin
            st_q <= dbahp_pkg::DBAHP_ARB_RELEASE;
          end
        end
        dbahp_pkg::DBAHP_ARB_SUSPEND: begin
          // Wait for the end of the current machine cycle (T3 or Ti).
          if (dma_cycle_end_i || mstate_q == 2'h0) begin
            st_q        <= dbahp_pkg::DBAHP_ARB_REQ;
            suspended_q <= 1'b1;
          end
        end
        dbahp_pkg::DBAHP_ARB_RELEASE: begin
          st_q <= dbahp_pkg::DBAHP_ARB_IDLE;
        end
        default: st_q <= dbahp_pkg::DBAHP_ARB_IDLE;
      endcase
    end
  end

  // Master cycle state counter, T1..T3 without waits.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mstate_q <= 2'h0;
    end else if (en_i) begin
      if (dma_go_o || mstate_q != 2'h0) begin
        if (mstate_q == dbahp_pkg::MASTER_STATES) begin
          mstate_q <= dma_go_o ? 2'h1 : 2'h0;
        end else begin
          mstate_q <= mstate_q + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bus.bus_request_n     <= 1'b1;
      bus.grant_chain_out_n <= 1'b1;
      bus.busy_o_dev        <= 1'b1;
      bus.busy_oe_dev       <= 1'b0;
    end else if (en_i) begin
      bus.bus_request_n <= !(dma_req_i || suspended_q) ||
                           mode0;
      bus.busy_o_dev  <= 1'b0;
      bus.busy_oe_dev <= (st_q == dbahp_pkg::DBAHP_ARB_OWN) ||
                         (st_q == dbahp_pkg::DBAHP_ARB_SUSPEND &&
                          !dma_cycle_end_i);
      bus.grant_chain_out_n <= !(grant && !dma_req_i && !suspended_q &&
                                 st_q == dbahp_pkg::DBAHP_ARB_IDLE);
    end
  end

  logic hold_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hold_q <= 1'b0;
    end else if (en_i) begin
      hold_q <= mode0 && (dma_req_i || suspended_q);
    end
  end

  // The engine starts only once busy is really driven low.
  assign dma_go_o        = (st_q == dbahp_pkg::DBAHP_ARB_OWN) && grant &&
                           bus.busy_oe_dev;
  assign dma_suspended_o = suspended_q;
  assign status = {11'h000, suspended_q, st_q[2], cpu_mode_i, dma_req_i};

  dbahp_slave u_slave (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .en_i      (en_i),
    .mode_i    (cpu_mode_i),
    .cs_n_i    (bus.chip_select_n),
    .rd_n_i    (bus.read_strobe_n),
    .wr_n_i    (bus.write_strobe_n),
    .hbe_n_i   (bus.high_byte_enable_n),
    .addr_i    (bus.addr),
    .data_i    (bus.data),
    .status_i  (status),
    .data_o    (bus.data_o_dev),
    .data_oe_o (sl_oe),
    .wait_o    (bus.wait_line),
    .ctrl_o    (ctrl_o)
  );
  // Slave drives data and wait only; address and strobes stay inputs.
  assign bus.data_oe_dev = sl_oe && !dma_go_o;
  assign bus.hold_request = hold_q;
endmodule
`default_nettype wire

// >>> rtl/dbahp_host.sv
`timescale 1ns/1ps
`default_nettype none
module dbahp_host (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        en_i,
  input  wire logic        grant_en_i,
  input  wire logic        cmd_valid_i,
  input  wire logic        cmd_write_i,
  input  wire logic [7:0]  cmd_addr_i,
  input  wire logic [15:0] cmd_wdata_i,
  input  wire logic        cmd_hbe_n_i,
  output logic             cmd_ready_o,
  output logic             rsp_valid_o,
  output logic [15:0]      rsp_rdata_o,
  dbahp_if.host            bus
);
  logic [2:0] t_q;
  logic       act_q;
  logic       wr_q;

  assign cmd_ready_o = !act_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bus.hold_grant  <= 1'b0;
      bus.bus_grant_n <= 1'b1;
    end else if (en_i) begin
      // The grant may serve a downstream master, so it follows grant_en_i.
      bus.hold_grant  <= grant_en_i;
      bus.bus_grant_n <= !grant_en_i;
    end
  end

  // T1..T5 per cycle, strobe released at T5 start, T6 acts as idle.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      act_q <= 1'b0;
      t_q   <= 3'h0;
      wr_q  <= 1'b0;
      bus.chip_select_n      <= 1'b1;
      bus.read_strobe_n      <= 1'b1;
      bus.write_strobe_n     <= 1'b1;
      bus.high_byte_enable_n <= 1'b1;
      bus.addr               <= 8'h00;
      bus.data_o_host        <= 16'h0000;
      bus.data_oe_host       <= 1'b0;
      rsp_valid_o            <= 1'b0;
      rsp_rdata_o            <= 16'h0000;
    end else if (en_i) begin
      rsp_valid_o <= 1'b0;
      if (!act_q && cmd_valid_i) begin
        act_q <= 1'b1;
        t_q   <= 3'h1;
        wr_q  <= cmd_write_i;
        bus.chip_select_n      <= 1'b0;
        bus.addr               <= cmd_addr_i;
        bus.high_byte_enable_n <= cmd_hbe_n_i;
        bus.read_strobe_n      <= cmd_write_i;
        bus.write_strobe_n     <= !cmd_write_i;
        bus.data_o_host        <= cmd_wdata_i;
        bus.data_oe_host       <= cmd_write_i;
      end else if (act_q) begin
        t_q <= t_q + 3'h1;
        if (t_q == 3'h4) begin
          // Strobes held through T4, released at T5 start.
          bus.read_strobe_n  <= 1'b1;
          bus.write_strobe_n <= 1'b1;
          bus.data_oe_host   <= 1'b0;
          if (!wr_q) begin
            rsp_rdata_o <= bus.data;
            rsp_valid_o <= 1'b1;
          end
        end else if (t_q == 3'h6) begin
          act_q             <= 1'b0;
          bus.chip_select_n <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bus.busy_o_host  <= 1'b1;
      bus.busy_oe_host <= 1'b0;
    end else if (en_i) begin
      bus.busy_o_host  <= 1'b1;
      bus.busy_oe_host <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/dbahp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dbahp_if;
  logic        bus_request_n;
  logic        hold_request;
  logic        bus_grant_n;
  logic        hold_grant;
  logic        grant_chain_out_n;
  logic        busy_o_dev;
  logic        busy_oe_dev;
  logic        busy_o_host;
  logic        busy_oe_host;
  logic        busy;
  logic        chip_select_n;
  logic        read_strobe_n;
  logic        write_strobe_n;
  logic        high_byte_enable_n;
  logic [7:0]  addr;
  logic [15:0] data_o_dev;
  logic        data_oe_dev;
  logic [15:0] data_o_host;
  logic        data_oe_host;
  logic [15:0] data;
  logic        wait_line;

  // Busy is open drain with pull-up; data resolves from the enables.
  assign busy = !((busy_oe_dev && !busy_o_dev) ||
                  (busy_oe_host && !busy_o_host));
  assign data = data_oe_dev ? data_o_dev :
                (data_oe_host ? data_o_host : 16'h0000);

  modport device (
    output bus_request_n, grant_chain_out_n, busy_o_dev, busy_oe_dev,
    output data_o_dev, data_oe_dev, wait_line, hold_request,
    input  bus_grant_n, hold_grant, busy, chip_select_n, read_strobe_n,
    input  write_strobe_n, high_byte_enable_n, addr, data
  );
  modport host (
    input  bus_request_n, grant_chain_out_n, busy, data, wait_line,
    input  hold_request,
    output bus_grant_n, hold_grant, busy_o_host, busy_oe_host,
    output chip_select_n, read_strobe_n, write_strobe_n,
    output high_byte_enable_n, addr, data_o_host, data_oe_host
  );
endinterface
`default_nettype wire

// >>> rtl/dbahp_pkg.sv
package dbahp_pkg;

  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned NUM_REGS   = 16;
  localparam int unsigned REG_IDX_W  = 4;

  localparam logic [1:0] CPU_MODE0 = 2'h0;
  localparam logic [1:0] CPU_MODE1 = 2'h1;
  localparam logic [1:0] CPU_MODE2 = 2'h2;
  localparam logic [1:0] CPU_MODE3 = 2'h3;

  // Minimum slave cycle lengths in states: read / write.
  localparam logic [2:0] M0_RD_STATES     = 3'h4;
  localparam logic [2:0] M0_WR_STATES     = 3'h4;
  localparam logic [2:0] M0_BACK_STATES   = 3'h5;
  localparam logic [2:0] M1_RD_STATES     = 3'h4;
  localparam logic [2:0] M1_WR_STATES     = 3'h5;
  localparam logic [2:0] M2_RD_STATES     = 3'h5;
  localparam logic [2:0] M2_WR_STATES     = 3'h6;
  localparam logic [2:0] M3_RD_STATES     = 3'h5;
  localparam logic [2:0] M3_WR_STATES     = 3'h5;

  // Master cycle length without wait states.
  localparam logic [1:0] MASTER_STATES    = 2'h3;

  // Slave cycle state at which data is driven or captured (T3 = 3).
  localparam logic [2:0] SLV_DATA_STATE   = 3'h3;
  localparam logic [2:0] SLV_STATE_ONE    = 3'h1;
  localparam logic [2:0] SLV_STATE_MAX    = 3'h7;

  localparam logic [15:0] REG_RESET       = 16'h0000;

  typedef enum logic [4:0] {
    DBAHP_ARB_IDLE    = 5'h01,
    DBAHP_ARB_REQ     = 5'h02,
    DBAHP_ARB_OWN     = 5'h04,
    DBAHP_ARB_RELEASE = 5'h08,
    DBAHP_ARB_SUSPEND = 5'h10
  } dbahp_arb_state_t;

  typedef enum logic [3:0] {
    DBAHP_SLV_IDLE    = 4'h1,
    DBAHP_SLV_RUN     = 4'h2,
    DBAHP_SLV_DONE    = 4'h4,
    DBAHP_SLV_GAP     = 4'h8
  } dbahp_slv_state_t;

  function automatic logic [15:0] dbahp_swap(input logic [15:0] d,
                                             input logic [1:0]  mode);
    // Mode 0 places odd bytes high; modes 2 and 3 place even bytes high.
    if (mode == CPU_MODE0) begin
      dbahp_swap = d;
    end else if (mode == CPU_MODE1) begin
      dbahp_swap = {8'h00, d[7:0]};
    end else begin
      dbahp_swap = {d[7:0], d[15:8]};
    end
  endfunction

endpackage

// >>> rtl/dbahp_slave.sv
`timescale 1ns/1ps
`default_nettype none
module dbahp_slave #(
  parameter int unsigned NREGS = dbahp_pkg::NUM_REGS
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        en_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic        cs_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic        hbe_n_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [15:0] data_i,
  input  wire logic [15:0] status_i,
  output logic [15:0]      data_o,
  output logic             data_oe_o,
  output logic             wait_o,
  output logic [15:0]      ctrl_o
);
  if (NREGS < 2 || NREGS > 16) begin : g_nregs_check
    $error("NREGS out of range");
  end

  dbahp_pkg::dbahp_slv_state_t st_q;
  logic [2:0]  cnt_q;
  logic        is_rd_q;
  logic [3:0]  idx_q;
  logic        hbe_n_q;
  logic [15:0] regs_q [NREGS];
  logic [15:0] rdata;
  logic        strobe;
  logic        strobe_end;

  assign strobe     = !rd_n_i || !wr_n_i;
  assign strobe_end = is_rd_q ? rd_n_i : wr_n_i;
  // Register 0 shows live block status; the others are plain storage.
  assign rdata = (idx_q == 4'h0) ? status_i : regs_q[idx_q];
  assign ctrl_o = regs_q[1];

  // Cycle sequencer: T1 on strobe seen with chip select low in mode 0.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q    <= dbahp_pkg::DBAHP_SLV_IDLE;
      cnt_q   <= dbahp_pkg::SLV_STATE_ONE;
      is_rd_q <= 1'b0;
      idx_q   <= 4'h0;
      hbe_n_q <= 1'b1;
    end else if (en_i) begin
      case (st_q)
        dbahp_pkg::DBAHP_SLV_IDLE, dbahp_pkg::DBAHP_SLV_GAP: begin
          if (!cs_n_i && strobe && mode_i == dbahp_pkg::CPU_MODE0) begin
            st_q    <= dbahp_pkg::DBAHP_SLV_RUN;
            cnt_q   <= dbahp_pkg::SLV_STATE_ONE;
            is_rd_q <= !rd_n_i;
            idx_q   <= addr_i[4:1];
            hbe_n_q <= hbe_n_i;
          end else begin
            st_q <= dbahp_pkg::DBAHP_SLV_IDLE;
          end
        end
        dbahp_pkg::DBAHP_SLV_RUN: begin
          if (cnt_q != dbahp_pkg::SLV_STATE_MAX) begin
            cnt_q <= cnt_q + 3'h1;
          end
          if (cnt_q >= dbahp_pkg::SLV_DATA_STATE && strobe_end) begin
            st_q <= dbahp_pkg::DBAHP_SLV_DONE;
          end
        end
        dbahp_pkg::DBAHP_SLV_DONE: begin
          st_q <= dbahp_pkg::DBAHP_SLV_GAP;
        end
        default: st_q <= dbahp_pkg::DBAHP_SLV_IDLE;
      endcase
    end
  end

  // Read data drive during T3 until the strobe rises.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      data_o    <= 16'h0000;
      data_oe_o <= 1'b0;
    end else if (en_i) begin
      if (st_q == dbahp_pkg::DBAHP_SLV_RUN && is_rd_q && !rd_n_i &&
          cnt_q == dbahp_pkg::SLV_DATA_STATE - 3'h1) begin
        data_o    <= dbahp_pkg::dbahp_swap(rdata, mode_i);
        data_oe_o <= 1'b1;
      end else if (rd_n_i) begin
        data_oe_o <= 1'b0;
      end
    end
  end

  // Write capture at T3 for registers other than 0; low byte always written, high byte only when the high byte enable is low.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NREGS; i++) regs_q[i] <= dbahp_pkg::REG_RESET;
    end else if (en_i) begin
      if (st_q == dbahp_pkg::DBAHP_SLV_RUN && !is_rd_q && !wr_n_i &&
          cnt_q == dbahp_pkg::SLV_DATA_STATE - 3'h1 && idx_q != 4'h0) begin
        if (!hbe_n_q) begin
          regs_q[idx_q][15:8] <= data_i[15:8];
        end
        regs_q[idx_q][7:0] <= data_i[7:0];
      end
    end
  end

  // Wait is held high at all times; no wait states are inserted.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wait_o <= 1'b1;
    end else if (en_i) begin
      wait_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> verif/dbahp_props.sv
`timescale 1ns/1ps
`default_nettype none
module dbahp_props (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] cpu_mode,
  input wire logic bus_request_n,
  input wire logic hold_request,
  input wire logic bus_grant_n,
  input wire logic grant_chain_out_n,
  input wire logic busy_oe_dev,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic data_oe_dev,
  input wire logic data_oe_host
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_chain_req;
    !bus_request_n |=> grant_chain_out_n;
  endproperty
  a_chain_req: assert property (p_chain_req)
    else $error("chain forwarded while requesting");

  property p_chain_grant;
    $fell(grant_chain_out_n) |-> !$past(bus_grant_n);
  endproperty
  a_chain_grant: assert property (p_chain_grant)
    else $error("chain forwarded without a grant");

  property p_take;
    $rose(busy_oe_dev) |-> !$past(bus_grant_n) && !$past(bus_request_n);
  endproperty
  a_take: assert property (p_take)
    else $error("busy taken without request and grant");

  property p_rd_start;
    $fell(read_strobe_n) && !chip_select_n && cpu_mode == 2'h0
      |-> !data_oe_dev ##[2:4] data_oe_dev;
  endproperty
  a_rd_start: assert property (p_rd_start)
    else $error("read data not driven in time");

  property p_rd_end;
    $rose(read_strobe_n) |-> ##[0:2] !data_oe_dev;
  endproperty
  a_rd_end: assert property (p_rd_end)
    else $error("data bus not released after read");

  property p_no_clash;
    !(data_oe_dev && data_oe_host);
  endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive the data bus");

  property p_cs_held;
    !read_strobe_n || !write_strobe_n |-> !chip_select_n;
  endproperty
  a_cs_held: assert property (p_cs_held)
    else $error("chip select high inside a cycle");

  property p_rd_hold;
    $fell(read_strobe_n) |-> !read_strobe_n [*3];
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read strobe released early");

  property p_wr_hold;
    $fell(write_strobe_n) |-> !write_strobe_n [*3];
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("write strobe released early");

  property p_gap;
    $rose(read_strobe_n) || $rose(write_strobe_n)
      |=> read_strobe_n && write_strobe_n;
  endproperty
  a_gap: assert property (p_gap)
    else $error("no idle state between slave cycles");

  property p_req_lane;
    (cpu_mode == 2'h0) ? bus_request_n : !hold_request;
  endproperty
  a_req_lane: assert property (p_req_lane)
    else $error("bus request raised on the wrong line for the mode");
endmodule
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic        we;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        hbe_n;
    logic [15:0] exp;
  } dbahp_row_t;
  logic        clk_i     = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic [1:0]  mode      = 2'h0;
  logic        dma_req   = 1'b0;
  logic        cyc_end   = 1'b0;
  logic        grant_en  = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        cmd_write = 1'b0;
  logic [7:0]  cmd_addr  = 8'h00;
  logic [15:0] cmd_wdata = 16'h0000;
  logic        cmd_hbe_n = 1'b1;
  logic        dma_go;
  logic        dma_susp;
  logic        cmd_ready;
  logic        rsp_valid;
  logic [15:0] ctrl;
  logic [15:0] rsp_rdata;
  logic [15:0] rd;
  int          err_count  = 0;
  int          num_checks = 0;
  int          n;
  dbahp_row_t  rows [9];

  always #5 clk_i = ~clk_i;

  dbahp_if dbahp_if_i ();
  dbahp_device dbahp_device_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(1'b1), .cpu_mode_i(mode),
    .dma_req_i(dma_req), .dma_cycle_end_i(cyc_end), .dma_go_o(dma_go),
    .dma_suspended_o(dma_susp), .ctrl_o(ctrl), .bus(dbahp_if_i)
  );
  dbahp_host dbahp_host_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(1'b1), .grant_en_i(grant_en),
    .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write),
    .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata),
    .cmd_hbe_n_i(cmd_hbe_n), .cmd_ready_o(cmd_ready),
    .rsp_valid_o(rsp_valid), .rsp_rdata_o(rsp_rdata), .bus(dbahp_if_i)
  );
  dbahp_props dbahp_props_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cpu_mode(mode),
    .bus_request_n(dbahp_if_i.bus_request_n),
    .hold_request(dbahp_if_i.hold_request),
    .bus_grant_n(dbahp_if_i.bus_grant_n),
    .grant_chain_out_n(dbahp_if_i.grant_chain_out_n),
    .busy_oe_dev(dbahp_if_i.busy_oe_dev),
    .chip_select_n(dbahp_if_i.chip_select_n),
    .read_strobe_n(dbahp_if_i.read_strobe_n),
    .write_strobe_n(dbahp_if_i.write_strobe_n),
    .data_oe_dev(dbahp_if_i.data_oe_dev),
    .data_oe_host(dbahp_if_i.data_oe_host)
  );

  task automatic chk1(input string name, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk16(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Holds the command until the host takes it, then waits for completion.
  task automatic host_cmd(input dbahp_row_t r);
    rd = 'x;
    @(posedge clk_i);
    cmd_valid <= 1'b1;
    cmd_write <= r.we;
    cmd_addr  <= r.addr;
    cmd_wdata <= r.wdata;
    cmd_hbe_n <= r.hbe_n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (cmd_ready !== 1'b1 && n < 20);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (rsp_valid === 1'b1) rd = rsp_rdata;
    end while (cmd_ready !== 1'b1 && n < 20);
    if (cmd_ready !== 1'b1) begin
      err_count++;
      $display("[FAIL] host cycle expected done seen stuck");
    end
  endtask

  task automatic wait_go(input logic v);
    n = 0;
    while (dma_go !== v && n < 30) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk_i);
    err_count++;
    $display("[FAIL] watchdog expected finish seen timeout");
    end_of_test();
  end

  initial begin
    rows[0] = '{1'b1, 8'h02, 16'hA5C3, 1'b0, 16'h0000};
    rows[1] = '{1'b0, 8'h02, 16'h0000, 1'b0, 16'hA5C3};
    rows[2] = '{1'b1, 8'h02, 16'h1234, 1'b1, 16'h0000};
    rows[3] = '{1'b0, 8'h02, 16'h0000, 1'b0, 16'hA534};
    rows[4] = '{1'b1, 8'h1E, 16'hBEEF, 1'b0, 16'h0000};
    rows[5] = '{1'b0, 8'h1E, 16'h0000, 1'b0, 16'hBEEF};
    rows[6] = '{1'b1, 8'h00, 16'hFFFF, 1'b0, 16'h0000};
    rows[7] = '{1'b0, 8'h03, 16'h0000, 1'b0, 16'hA534};
    rows[8] = '{1'b0, 8'h00, 16'h0000, 1'b0, 16'h0000};
    repeat (10) @(posedge clk_i);
    chk1("wait", 1'b1, dbahp_if_i.wait_line);
    chk1("request", 1'b1, dbahp_if_i.bus_request_n);
    chk1("chain", 1'b1, dbahp_if_i.grant_chain_out_n);
    chk1("data oe", 1'b0, dbahp_if_i.data_oe_dev);
    rst_n_i <= 1'b1;
    foreach (rows[i]) begin
      host_cmd(rows[i]);
      if (!rows[i].we) chk16("read data", rows[i].exp, rd);
    end
    chk16("ctrl", 16'hA534, ctrl);
    chk1("wait idle", 1'b1, dbahp_if_i.wait_line);
    dma_req <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk1("hold", 1'b1, dbahp_if_i.hold_request);
    chk1("request m0", 1'b1, dbahp_if_i.bus_request_n);
    dma_req <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk1("hold off", 1'b0, dbahp_if_i.hold_request);
    // Slave cycles outside mode 0 are ignored by this device.
    mode <= 2'h1;
    host_cmd('{1'b1, 8'h02, 16'h7777, 1'b0, 16'h0000});
    host_cmd('{1'b0, 8'h02, 16'h0000, 1'b0, 16'h0000});
    chk16("mode1 read", 16'h0000, rd);
    chk16("mode1 ctrl", 16'hA534, ctrl);
    @(posedge clk_i);
    dma_req <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk1("request", 1'b0, dbahp_if_i.bus_request_n);
    chk1("go no grant", 1'b0, dma_go);
    grant_en <= 1'b1;
    wait_go(1'b1);
    chk1("go", 1'b1, dma_go);
    chk1("busy owned", 1'b0, dbahp_if_i.busy);
    chk1("chain own", 1'b1, dbahp_if_i.grant_chain_out_n);
    grant_en <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk1("busy held", 1'b0, dbahp_if_i.busy);
    chk1("susp early", 1'b0, dma_susp);
    cyc_end <= 1'b1;
    @(posedge clk_i);
    cyc_end <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk1("suspended", 1'b1, dma_susp);
    chk1("busy free", 1'b1, dbahp_if_i.busy);
    grant_en <= 1'b1;
    wait_go(1'b1);
    chk1("resume", 1'b1, dma_go);
    chk1("busy again", 1'b0, dbahp_if_i.busy);
    dma_req <= 1'b0;
    cyc_end <= 1'b1;
    @(posedge clk_i);
    cyc_end <= 1'b0;
    n = 0;
    while (dbahp_if_i.grant_chain_out_n !== 1'b0 && n < 30) begin
      @(posedge clk_i);
      n++;
    end
    chk1("chain fwd", 1'b0, dbahp_if_i.grant_chain_out_n);
    chk1("go idle", 1'b0, dma_go);
    dma_req <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk1("chain req", 1'b1, dbahp_if_i.grant_chain_out_n);
    end_of_test();
  end
endmodule
`default_nettype wire
